// >>> msel_pkg.sv
// Purpose : constants for the mute input source selector
// Assumes : 32-bit apb data, one aligned word per register
// Notes   : shared by the top and the source multiplexer
package msel_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          MSEL_ADDR_W      = 32;
  localparam int          MSEL_DATA_W      = 32;
  localparam int          MSEL_SEL_W       = 3;
  localparam logic [31:0] MSEL_CFG_ADDR    = 32'h4000_0020;
  localparam int          MSEL_SEL_LSB     = 0;
  localparam logic [2:0]  MSEL_SEL_RESET   = 3'h0;
  localparam logic [31:0] MSEL_RSVD_READ   = 32'h0000_0000;
  localparam logic [31:0] MSEL_UNMAP_READ  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // source codes
  // ---------------------------------------------------------------
  localparam logic [2:0]  MSEL_SRC_ZERO    = 3'h0;
  localparam logic [2:0]  MSEL_SRC_P0D7    = 3'h1;
  localparam logic [2:0]  MSEL_SRC_P0D8    = 3'h2;
  localparam logic [2:0]  MSEL_SRC_P0D9    = 3'h3;
  localparam logic [2:0]  MSEL_SRC_HFCLK   = 3'h4;
  localparam logic [2:0]  MSEL_SRC_SP0DI   = 3'h5;
  localparam logic [2:0]  MSEL_SRC_SP0CS   = 3'h6;
  localparam logic [2:0]  MSEL_SRC_SP0EN   = 3'h7;

endpackage

// >>> msel_mux.sv
// Purpose : eight-way source multiplexer for the mute input
// Assumes : sources already synchronised to pclk
// Notes   : purely combinational
module msel_mux
  import msel_pkg::*;
(
  // select
  input  wire logic [2:0] sel,
  // sources, index equals code
  input  wire logic [7:0] src,
  // result
  output logic            y
);

  always_comb begin
    y = 1'b0;
    case (sel)
      MSEL_SRC_ZERO: y = 1'b0;
      default:       y = src[sel];
    endcase
  end

endmodule

// >>> msel_top.sv
// Purpose : apb register and source select for the port-2 mute input
// Assumes : pins arrive asynchronous and are synchronised here
// Notes   : switching between sources is not glitch free
//
// Function
// - select field bits 2:0 is read/write and resets to zero.
// - reserved bits 31:3 read with no guaranteed value; here zero.
// - code 000 drives constant zero onto the mute input.
// - codes 001-011 route port-0 data pins 7, 8, 9 shared lines.
// - code 100 routes the port-2 high-frequency receive clock.
// - codes 101-111 route first serial-peripheral data-in, select, enable pins.
module msel_top
  import msel_pkg::*;
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [MSEL_ADDR_W-1:0] paddr,
  input  wire logic [MSEL_DATA_W-1:0] pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [MSEL_DATA_W-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  // candidate pins
  input  wire logic                   port0_serial_data_pin7,
  input  wire logic                   port0_serial_data_pin8,
  input  wire logic                   port0_serial_data_pin9,
  input  wire logic                   port2_hf_receive_clock,
  input  wire logic                   first_serial_periph_data_in_pin,
  input  wire logic                   first_serial_periph_select_pin,
  input  wire logic                   first_serial_periph_enable_pin,
  // mute input of the port
  output logic                        mute_in,
  output logic      [2:0]             mute_source_sel
);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic [2:0]             sel_q;
  logic [2:0]             sel_d;
  logic [MSEL_DATA_W-1:0] rdata_q;
  logic [MSEL_DATA_W-1:0] rdata_d;
  logic                   hit;
  logic                   wr_en;
  logic                   rd_en;

  assign hit     = (paddr == MSEL_CFG_ADDR);
  assign wr_en   = psel && penable && pwrite && hit && pstrb[0];
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    sel_d   = sel_q;
    rdata_d = rdata_q;
    if (wr_en) begin
      sel_d = pwdata[MSEL_SEL_LSB +: MSEL_SEL_W];
    end
    if (rd_en) begin
      if (hit) begin
        rdata_d = MSEL_RSVD_READ;
        rdata_d[MSEL_SEL_LSB +: MSEL_SEL_W] = sel_q;
      end else begin
        rdata_d = MSEL_UNMAP_READ;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q   <= MSEL_SEL_RESET;
      rdata_q <= MSEL_UNMAP_READ;
    end else begin
      sel_q   <= sel_d;
      rdata_q <= rdata_d;
    end
  end

  assign prdata          = rdata_q;
  assign mute_source_sel = sel_q;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] pin_raw;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] sync1_d;
  logic [7:0] sync2_d;
  logic       mute_d;
  logic       mute_q;

  assign pin_raw = {first_serial_periph_enable_pin, first_serial_periph_select_pin,
                    first_serial_periph_data_in_pin, port2_hf_receive_clock,
                    port0_serial_data_pin9, port0_serial_data_pin8,
                    port0_serial_data_pin7, 1'b0};

  always_comb begin
    sync1_d = pin_raw;
    sync2_d = sync1_q;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= sync1_d[gi];
          sync2_q[gi] <= sync2_d[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // source select
  // ---------------------------------------------------------------
  msel_mux u_mux (
    .sel (sel_q),
    .src (sync2_q),
    .y   (mute_d)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_q <= 1'b0;
    end else begin
      mute_q <= mute_d;
    end
  end

  assign mute_in = mute_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sel_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> sel_q == MSEL_SEL_RESET)
    else $error("select not zero after reset");
  mute_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> !mute_in)
    else $error("mute not zero after reset");
  bus_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable |-> pready && !pslverr)
    else $error("access not completed cleanly");
  sel_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en |=> sel_q == $past(pwdata[MSEL_SEL_LSB +: MSEL_SEL_W]))
    else $error("select write lost");
  sel_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_en |=> $stable(sel_q))
    else $error("select changed without write");
  strb_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && hit && !pstrb[0] |=> $stable(sel_q))
    else $error("write without strobe applied");
  read_data_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && hit |=> prdata[MSEL_SEL_LSB +: MSEL_SEL_W] == $past(sel_q))
    else $error("select read back wrong");
  rd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !rd_en |=> $stable(prdata))
    else $error("read data changed without read");
  rsvd_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && hit |=> prdata[31:3] == 29'h0)
    else $error("reserved bits not zero");
  unmap_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && !hit |=> prdata == MSEL_UNMAP_READ)
    else $error("unmapped read not zero");

  // ---------------------------------------------------------------
  // route checks
  // ---------------------------------------------------------------
  zero_src_a: assert property (@(posedge pclk) disable iff (!presetn)
      sel_q == MSEL_SRC_ZERO |=> !mute_in)
    else $error("mute not zero for code 0");
  p0d7_src_a: assert property (@(posedge pclk) disable iff (!presetn)
      sel_q == MSEL_SRC_P0D7 |=> mute_in == $past(sync2_q[1]))
    else $error("pin7 route wrong");
  p0d8_src_a: assert property (@(posedge pclk) disable iff (!presetn)
      sel_q == MSEL_SRC_P0D8 |=> mute_in == $past(sync2_q[2]))
    else $error("pin8 route wrong");
  p0d9_src_a: assert property (@(posedge pclk) disable iff (!presetn)
      sel_q == MSEL_SRC_P0D9 |=> mute_in == $past(sync2_q[3]))
    else $error("pin9 route wrong");
  hf_src_a: assert property (@(posedge pclk) disable iff (!presetn)
      sel_q == MSEL_SRC_HFCLK |=> mute_in == $past(sync2_q[4]))
    else $error("clock route wrong");
  sp_di_src_a: assert property (@(posedge pclk) disable iff (!presetn)
      sel_q == MSEL_SRC_SP0DI |=> mute_in == $past(sync2_q[5]))
    else $error("data-in route wrong");
  sp_cs_src_a: assert property (@(posedge pclk) disable iff (!presetn)
      sel_q == MSEL_SRC_SP0CS |=> mute_in == $past(sync2_q[6]))
    else $error("select pin route wrong");
  sp_src_a: assert property (@(posedge pclk) disable iff (!presetn)
      sel_q == MSEL_SRC_SP0EN |=> mute_in == $past(sync2_q[7]))
    else $error("enable route wrong");
  mute_lag_a: assert property (@(posedge pclk) disable iff (!presetn)
      sel_q == $past(sel_q) && sel_q == $past(sel_q, 2) |=> mute_in == $past(pin_raw[sel_q], 3))
    else $error("pin to mute latency wrong");
  sel_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en |=> ##1 $past(sel_q) == $past(pwdata[MSEL_SEL_LSB +: MSEL_SEL_W], 2)
        && mute_in == ($past(sel_q) == MSEL_SRC_ZERO ? 1'b0 : $past(sync2_q[sel_q])))
    else $error("select not applied");

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (MSEL_SEL_LSB + MSEL_SEL_W > MSEL_DATA_W) begin : g_bad_field
    $error("select field lies outside the data word");
  end
  if (MSEL_SEL_W != 3) begin : g_bad_width
    $error("source multiplexer serves a 3-bit select only");
  end

endmodule

// >>> msel_top_test.sv
// Purpose : self-checking bench for the mute input source selector
// Assumes : zero-wait apb slave, mute_in lags pins by three cycles
// Notes   : reserved read bits are not compared
module msel_top_test
  import msel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mute_in;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:1]  pins;
  logic [2:0]  mute_source_sel;
  int          fail_count, checks_done;
  msel_top u_msel_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port0_serial_data_pin7(pins[1]), .port0_serial_data_pin8(pins[2]), .port0_serial_data_pin9(pins[3]),
    .port2_hf_receive_clock(pins[4]), .first_serial_periph_data_in_pin(pins[5]),
    .first_serial_periph_select_pin(pins[6]), .first_serial_periph_enable_pin(pins[7]),
    .mute_in(mute_in), .mute_source_sel(mute_source_sel));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // write data bits 31:3 always zero, a full apb cycle
  task automatic apb(input logic wr, input logic [31:0] a, input logic [2:0] wd, input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {29'h0, wd};
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      close_out();
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk(mute_in, 0, "mute after reset");
    chk(mute_source_sel, 0, "select output after reset");
    apb(1'b0, MSEL_CFG_ADDR, 3'h0, 4'h0);
    chk(rd[2:0], 0, "select after reset");
    $display("reset test done");
  endtask
  task automatic t_route();
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, MSEL_CFG_ADDR, c[2:0], 4'hF);
      @(posedge pclk);
      chk(mute_source_sel, c, "select next cycle");
      pins <= (c == 0) ? 7'h7F : 7'(1 << (c - 1));
      repeat (5) @(posedge pclk);
      chk(mute_in, c != 0, "routed high");
      pins <= (c == 0) ? 7'h00 : ~7'(1 << (c - 1));
      repeat (5) @(posedge pclk);
      chk(mute_in, 0, "routed low");
      apb(1'b0, MSEL_CFG_ADDR, 3'h0, 4'h0);
      chk(rd[2:0], c, "read back");
    end
    $display("route test done");
  endtask
  task automatic t_refuse();
    apb(1'b1, MSEL_CFG_ADDR, 3'h2, 4'hF);
    apb(1'b1, MSEL_CFG_ADDR + 32'h4, 3'h5, 4'hF);
    apb(1'b1, MSEL_CFG_ADDR, 3'h6, 4'hE);
    apb(1'b0, MSEL_CFG_ADDR, 3'h0, 4'h0);
    chk(rd[2:0], 3'h2, "ignored writes");
    apb(1'b0, MSEL_CFG_ADDR + 32'h4, 3'h0, 4'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(pslverr, 1'b0, "no error response");
    $display("refuse test done");
  endtask
  task automatic t_midreset();
    @(posedge pclk);
    pins <= 7'h7F;
    repeat (4) @(posedge pclk);
    chk(mute_in, 1, "mute before second reset");
    presetn <= 1'b0;
    @(posedge pclk);
    chk(mute_source_sel, 0, "select in second reset");
    chk(mute_in, 0, "mute in second reset");
    presetn <= 1'b1;
    apb(1'b0, MSEL_CFG_ADDR, 3'h0, 4'h0);
    chk(rd[2:0], 0, "select after second reset");
    $display("mid reset test done");
  endtask
  // ---------------------------------------------------------------
  // clock, reset and sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, pins} = '0;
    fail_count = 0;
    checks_done = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_route();
    t_midreset();
    t_refuse();
    close_out();
  end
endmodule
